// ### bench/ssp_host_model.sv
`default_nettype none

module ssp_host_model (
  input  wire logic pol_i,     // clock idle level
  input  wire logic pha_i,     // sample on trailing edge
  input  wire logic lvl_i,     // select active level
  input  wire logic miso_i,    // data from slave
  input  wire logic miso_oe_i, // slave drive enable
  output var logic  sclk_o,    // serial clock
  output var logic  sel_o,     // chip select
  output var logic  mosi_o     // data to slave
);
  timeunit 1ns;
  timeprecision 100ps;

  // park lines; the clock rests at its idle level outside frames
  task automatic idle();
    sclk_o = pol_i;
    sel_o  = ~lvl_i;
    mosi_o = 1'b0;
  endtask

  // select is held fixed for the whole frame
  task automatic open_frame(input logic act);
    sel_o = act ? lvl_i : ~lvl_i;
    #48;
  endtask

  // released data line flips so a stale bit never looks like data
  task automatic close_frame();
    sel_o  = ~lvl_i;
    mosi_o = ~mosi_o;
    #60;
  endtask

  // eight pulses, msb first; an undriven data out reads inverted
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (!pha_i) mosi_o = tx[i];
      #24;
      sclk_o = ~pol_i;
      if (!pha_i) rx[i] = miso_oe_i ? miso_i : ~miso_i;
      else mosi_o = tx[i];
      #24;
      sclk_o = pol_i;
      if (pha_i) rx[i] = miso_oe_i ? miso_i : ~miso_i;
    end
  endtask
endmodule

`default_nettype wire

// ### bench/ssp_slave_bench.sv
`default_nettype none

module ssp_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ssp_pkg::*;

  localparam int LIMIT = 80000; // cycles; the run needs about 27000

  logic         sys_clk;
  logic         rst;
  logic         sclk;
  logic         sel;
  logic         mosi;
  logic         miso;
  logic         miso_oe;
  logic [3:0]   straps;  // polarity, phase, select level, echo
  logic         dead;    // mode pin high: serial mode off
  logic [7:0]   rdata;
  logic [7:0]   junk;    // memory output outside read cycles
  ssp_cfg_t     cfg;
  ssp_stat_t    stat;
  ssp_mem_req_t req;
  logic [15:0]  wq[$];   // writes seen: address, data
  logic [7:0]   rq[$];   // read addresses seen
  int           errors;
  int           checked;
  int           cycles;

  ssp_slave u_ssp_slave (
    .sys_clk_i(sys_clk), .rst_i(rst), .serial_clock_in_i(sclk),
    .select_i(sel), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .strap_polarity_pin_i(straps[3]), .strap_phase_pin_i(straps[2]),
    .strap_select_level_pin_i(straps[1]), .strap_echo_pin_i(straps[0]),
    .iface_sel_low_i(1'b0), .iface_sel_high_i(dead),
    .rd_strobe_n_i(1'b0), .wr_strobe_n_i(1'b0),
    .cfg_o(cfg), .stat_o(stat), .mem_req_o(req), .mem_rdata_i(rdata)
  );

  ssp_host_model u_host (
    .pol_i(straps[3]), .pha_i(straps[2]), .lvl_i(straps[1]),
    .miso_i(miso), .miso_oe_i(miso_oe),
    .sclk_o(sclk), .sel_o(sel), .mosi_o(mosi)
  );

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  function automatic logic [7:0] mem_val(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  // zero-wait memory: data stands only in the cycle of the read pulse,
  // which is the cycle the port captures it in
  assign rdata = req.rd ? mem_val(req.addr) : junk;

  always @(posedge sys_clk) begin
    junk <= ~junk;
    if (req.wr) wq.push_back({req.addr, req.wdata});
    if (req.rd) rq.push_back(req.addr);
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      final_report();
    end
  end

  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // offset keeps link edges clear of memory clock edges
  task automatic begin_frame(input logic act);
    wq.delete();
    rq.delete();
    @(negedge sys_clk);
    #0.7;
    u_host.open_frame(act);
  endtask

  // one transaction; pf first sends a six-byte protocol reset sequence
  task automatic run(input logic [7:0] a, input logic [7:0] c,
                     input logic pf);
    logic [7:0] rx;
    logic [7:0] d;
    logic [7:0] sent[$];
    logic       good;
    good = c[6:4] == 3'h0 && c[3:0] != 4'h0;
    // an address of FFH would itself restart the protocol
    if (a == 8'hFF) a = 8'hFE;
    begin_frame(1'b1);
    if (pf) begin
      // reset as address, as control and out of the hunt state
      u_host.xfer(8'hFF, rx);
      u_host.xfer(~a, rx);
      u_host.xfer(8'hFF, rx);
      u_host.xfer(~a, rx);
      u_host.xfer(8'h80, rx);
      u_host.xfer(8'hFF, rx);
    end
    u_host.xfer(a, rx);
    if (!pf) cmp("sync0", straps[0] ? 8'hAA : 8'h00, rx);
    u_host.xfer(c, rx);
    if (!pf) cmp("sync1", straps[0] ? 8'h55 : 8'h00, rx);
    for (int i = 0; i < c[3:0]; i++) begin
      d = 8'($urandom);
      if (!good && d == 8'hFF) d = 8'h00;
      sent.push_back(d);
      u_host.xfer(c[7] ? d : 8'hFF, rx);
      if (!c[7] && good) cmp("rdata", mem_val(8'(a + i)), rx);
    end
    #100;
    cmp("hunt", {7'h00, !good}, {7'h00, stat.resync_needed});
    if (good) cmp("left", 8'h00, {4'h0, stat.serial_byte_count});
    u_host.close_frame();
    cmp("oe", 8'h00, {7'h00, miso_oe});
    cmp("selected", 8'h00, {7'h00, stat.selected});
    cmp("count", good ? 8'(c[3:0]) : 8'h00,
        8'(c[7] ? wq.size() : rq.size()));
    foreach (wq[i]) begin
      cmp("waddr", 8'(a + i), wq[i][15:8]);
      cmp("wdata", sent[i], wq[i][7:0]);
    end
    foreach (rq[i]) cmp("raddr", 8'(a + i), rq[i]);
  endtask

  // three resets: random straps, inverted straps, serial mode off
  initial begin
    logic [3:0] rs;
    logic [7:0] rx;
    rst = 1'b1;
    straps = 4'h0;
    dead = 1'b0;
    junk = 8'h00;
    errors = 0;
    checked = 0;
    cycles = 0;
    u_host.idle();
    void'($urandom(1));
    rs = 4'($urandom);
    for (int p = 0; p < 3; p++) begin
      @(negedge sys_clk);
      rst = 1'b1;
      straps = p == 1 ? ~rs : rs;
      dead = p == 2;
      u_host.idle();
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      cmp("cfg", {3'h0, straps, !dead}, {3'h0, cfg});
      if (!dead) begin
        run(8'hFE, 8'h8F, 1'b0);
        run(8'($urandom), 8'h0F, 1'b0);
        run(8'($urandom), 8'h01, 1'b0);
        run(8'($urandom), 8'hA3, 1'b0);
        run(8'($urandom), 8'h81, 1'b1);
        run(8'($urandom), 8'h80, 1'b0);
        run(8'($urandom), 8'h05, 1'b1);
        repeat (6) run(8'($urandom),
                       {1'($urandom), 3'h0, 4'(1 + $urandom % 15)}, 1'b0);
      end
      // traffic that must never reach memory
      begin_frame(dead);
      repeat (4) u_host.xfer(8'h81, rx);
      u_host.close_frame();
      cmp("stray", 8'h00, 8'(wq.size() + rq.size()));
    end
    final_report();
  end
endmodule

`default_nettype wire

// ### bench/ssp_slave_props.sv
`default_nettype none

module ssp_slave_props (
  input wire logic                  sys_clk_i,         // memory clock
  input wire logic                  rst_i,             // sync reset
  input wire logic                  serial_clock_in_i, // link clock
  input wire logic                  select_i,          // select pin
  input wire logic                  miso_oe_o,         // drive enable
  input wire ssp_pkg::ssp_cfg_t     cfg_o,             // captured straps
  input wire ssp_pkg::ssp_stat_t    stat_o,            // port status
  input wire ssp_pkg::ssp_mem_req_t mem_req_o          // memory request
);
  import ssp_pkg::*;

  logic [7:0] last_addr; // address of the previous access
  logic       seen;      // an access already happened in this select

  // decoded helpers
  wire acc    = mem_req_o.rd | mem_req_o.wr;
  wire sel_on = select_i == cfg_o.select_active_level;

  // raw deselect clears seen, so each select restarts the step check
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !sel_on) seen <= 1'b0;
    else if (acc) seen <= 1'b1;
    if (acc) last_addr <= mem_req_o.addr;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // a byte takes far longer than eight cycles at any legal link rate
  sequence s_quiet8;
    (!mem_req_o.rd && !mem_req_o.wr) [*8];
  endsequence

  a_oe_select: assert property (miso_oe_o |-> sel_on)
    else $error("data out driven while deselected");
  a_dead_quiet: assert property (
    !cfg_o.serial_mode |-> !miso_oe_o && !acc)
    else $error("port active outside serial mode");
  a_wr_spaced: assert property (mem_req_o.wr |=> s_quiet8)
    else $error("writes closer than one byte");
  a_rd_single: assert property (mem_req_o.rd |=> !mem_req_o.rd)
    else $error("read pulse longer than one cycle");
  a_addr_step: assert property (
    acc && seen |-> mem_req_o.addr == 8'(last_addr + 8'h01))
    else $error("access address did not step by one");
  a_dir_excl: assert property (!(mem_req_o.rd && mem_req_o.wr))
    else $error("read and write in the same cycle");
  a_hunt_idle: assert property (
    stat_o.resync_needed |-> !acc && !stat_o.busy)
    else $error("activity while waiting for resync");
  a_cfg_frozen: assert property (!$past(rst_i) |-> $stable(cfg_o))
    else $error("configuration changed after reset");
endmodule

bind ssp_slave ssp_slave_props u_props (
  .sys_clk_i         (sys_clk_i),
  .rst_i             (rst_i),
  .serial_clock_in_i (serial_clock_in_i),
  .select_i          (select_i),
  .miso_oe_o         (miso_oe_o),
  .cfg_o             (cfg_o),
  .stat_o            (stat_o),
  .mem_req_o         (mem_req_o)
);

`default_nettype wire

// ### hw/ssp_params.svh
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// bytes sent back while address and control arrive
`define SSP_SYNC_FIRST  8'hAA
`define SSP_SYNC_SECOND 8'h55
`define SSP_FILL_BYTE   8'h00
// protocol reset value for address or control byte
`define SSP_RESET_BYTE  8'hFF

// control byte layout
`define SSP_DIR_BIT     7
`define SSP_SYNC_HI     6
`define SSP_SYNC_LO     4
`define SSP_CNT_HI      3
`define SSP_CNT_LO      0
`define SSP_CNT_ZERO    4'h0
`define SSP_CNT_ONE     4'h1

// bit position of the last bit in a byte
`define SSP_LAST_BIT    3'h7
// load counter saturates here
`define SSP_LOAD_SAT    2'h2

// indices into the synchronised input vector
`define SSP_IN_CLK      0
`define SSP_IN_SEL      1
`define SSP_IN_TGL      2
`define SSP_IN_POL      3
`define SSP_IN_PHA      4
`define SSP_IN_LVL      5
`define SSP_IN_ECHO     6
`define SSP_IN_MLO      7
`define SSP_IN_MHI      8
`define SSP_IN_RDN      9
`define SSP_IN_WRN      10
`define SSP_IN_NUM      11

`endif

// ### hw/ssp_pkg.sv
`default_nettype none

package ssp_pkg;

  // protocol states of the memory-clock side
  typedef enum logic [2:0] {
    SSP_IDLE,
    SSP_ADDR,
    SSP_CTRL,
    SSP_DATA,
    SSP_DONE,
    SSP_HUNT
  } ssp_state_t;

  // configuration caught from straps at reset
  typedef struct packed {
    logic clock_idle_polarity;
    logic sample_edge_phase;
    logic select_active_level;
    logic sync_echo_enable;
    logic serial_mode;
  } ssp_cfg_t;

  // request towards the internal memory bus
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssp_mem_req_t;

  // status of the port
  typedef struct packed {
    logic       selected;
    logic       resync_needed;
    logic       busy;
    logic [3:0] serial_byte_count;
  } ssp_stat_t;

endpackage

`default_nettype wire

// ### hw/ssp_slave.sv
// How it works
// - both data lines carry each byte most significant bit first.
// - slave only; master clocks; eight clock pulses move one byte each way.
// - transfers are whole bytes, one bit per clock pulse.
// - echo AAH then 55H during address and control, or 00H twice.
// - an FFH address or control byte restarts the protocol at address.
// - polarity strap sets the serial clock idle level.
// - phase strap with polarity picks the sampling edge.
// - select level strap picks active high or active low select.
// - control bit 7 zero reads from device, one writes into it.
// - nonzero sync bits in control byte force resynchronisation.
// - byte count 1 to 15; zero forces resynchronisation.
// - first data byte uses sent address; address increments per byte.
// - during read data, input line content is ignored.
// - serial input shifts in only while select is asserted.
// - output line released whenever select is not asserted.
`include "ssp_params.svh"
`default_nettype none

module ssp_slave (
  input  wire logic              sys_clk_i,         // memory clock
  input  wire logic              rst_i,             // sync reset, high
  input  wire logic              serial_clock_in_i, // link clock
  input  wire logic              select_i,          // chip select pin
  input  wire logic              mosi_i,            // serial data in
  output logic                   miso_o,            // serial data out
  output logic                   miso_oe_o,         // drive enable
  input  wire logic              strap_polarity_pin_i,   // idle level
  input  wire logic              strap_phase_pin_i,      // clock phase
  input  wire logic              strap_select_level_pin_i, // sel level
  input  wire logic              strap_echo_pin_i,  // sync echo
  input  wire logic              iface_sel_low_i,   // mode pin 0
  input  wire logic              iface_sel_high_i,  // mode pin 1
  input  wire logic              rd_strobe_n_i,     // read strobe pin
  input  wire logic              wr_strobe_n_i,     // write strobe pin
  output ssp_pkg::ssp_cfg_t      cfg_o,             // captured straps
  output ssp_pkg::ssp_stat_t     stat_o,            // port status
  output ssp_pkg::ssp_mem_req_t  mem_req_o,         // memory request
  input  wire logic [7:0]        mem_rdata_i        // read data, same cycle as rd
);
  import ssp_pkg::*;

  // select pin compared with the strapped active level
  function automatic logic ssp_sel_on(input logic pin,
                                      input logic level);
    ssp_sel_on = (pin == level);
  endfunction

  ssp_cfg_t                cfg;
  ssp_state_t              st;
  ssp_state_t              next_st;
  logic [`SSP_IN_NUM-1:0]  raw;
  logic [`SSP_IN_NUM-1:0]  sync1;
  logic [`SSP_IN_NUM-1:0]  sync2;
  logic [`SSP_IN_NUM-1:0]  sync3;
  logic [`SSP_IN_NUM-1:0]  filt;
  logic                    clk_d;
  logic                    tgl_d;
  logic                    sel_d;
  logic                    link_clk;
  logic                    link_rst;
  logic [2:0]              lcnt;
  logic [6:0]              lsh;
  logic                    ltgl;
  logic [7:0]              lbyte;
  logic [7:0]              addr;
  logic [3:0]              cnt;
  logic                    dir;
  logic [3:0]              rd_left;
  logic                    rd_wait;
  ssp_mem_req_t            mem_req;
  logic [7:0]              tx_sh;
  logic [7:0]              next_tx;
  logic                    nxt_ok;
  logic                    pend;
  logic [1:0]              lc;
  logic [2:0]              scnt;
  logic                    sel_on_f;

  // ---- link domain: byte assembly on the sampling edge ----
  // straps are static after reset, so xor-ing them into the clock
  // path is glitch free once the port is in use
  assign link_clk = serial_clock_in_i ^
                    (cfg.clock_idle_polarity ^ cfg.sample_edge_phase);
  // held in reset whenever select is off: partial bytes are dropped
  assign link_rst = ~(ssp_sel_on(select_i, cfg.select_active_level)
                      & cfg.serial_mode);

  // shift register and bit counter, msb arrives first
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      lcnt <= 3'h0;
      lsh  <= 7'h00;
      ltgl <= 1'b0;
    end else begin
      lsh  <= {lsh[5:0], mosi_i};
      lcnt <= lcnt + 3'h1;
      if (lcnt == `SSP_LAST_BIT) begin
        ltgl <= ~ltgl;
      end
    end
  end

  // finished byte, held stable for a whole byte time
  always_ff @(posedge link_clk) begin
    if (lcnt == `SSP_LAST_BIT) begin
      lbyte <= {lsh, mosi_i};
    end
  end

  // ---- synchronisers into the memory clock ----
  assign raw[`SSP_IN_CLK]  = serial_clock_in_i;
  assign raw[`SSP_IN_SEL]  = select_i;
  assign raw[`SSP_IN_TGL]  = ltgl;
  assign raw[`SSP_IN_POL]  = strap_polarity_pin_i;
  assign raw[`SSP_IN_PHA]  = strap_phase_pin_i;
  assign raw[`SSP_IN_LVL]  = strap_select_level_pin_i;
  assign raw[`SSP_IN_ECHO] = strap_echo_pin_i;
  assign raw[`SSP_IN_MLO]  = iface_sel_low_i;
  assign raw[`SSP_IN_MHI]  = iface_sel_high_i;
  assign raw[`SSP_IN_RDN]  = rd_strobe_n_i;
  assign raw[`SSP_IN_WRN]  = wr_strobe_n_i;

  // three stages; a level is taken once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    sync1 <= raw;
    sync2 <= sync1;
    sync3 <= sync2;
    filt  <= (filt & ~(sync2 ~^ sync3)) |
             (sync3 & (sync2 ~^ sync3));
  end

  // straps latched while reset is held
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg.clock_idle_polarity <= filt[`SSP_IN_POL];
      cfg.sample_edge_phase   <= filt[`SSP_IN_PHA];
      cfg.select_active_level <= filt[`SSP_IN_LVL];
      cfg.sync_echo_enable    <= filt[`SSP_IN_ECHO];
      cfg.serial_mode <= ~(filt[`SSP_IN_MLO] | filt[`SSP_IN_MHI] |
                           filt[`SSP_IN_RDN] | filt[`SSP_IN_WRN]);
    end
  end

  // edge history of the filtered levels
  always_ff @(posedge sys_clk_i) begin
    clk_d <= filt[`SSP_IN_CLK];
    tgl_d <= filt[`SSP_IN_TGL];
    sel_d <= sel_on_f;
  end

  // ---- decode of filtered link activity ----
  logic       clk_edge;
  logic       at_sample;
  logic       at_shift;
  logic       byte_evt;
  logic [7:0] rx_byte;
  logic       is_reset;
  logic       ctrl_bad;
  logic [3:0] ctrl_cnt;
  logic       last;
  logic       do_load;
  logic       rd_first;
  logic       rd_more;
  logic       issue_rd;
  logic       do_write;
  logic       fill_evt;
  logic [7:0] sync_a;
  logic [7:0] sync_b;

  assign sel_on_f  = ~rst_i & cfg.serial_mode &
                     ssp_sel_on(filt[`SSP_IN_SEL],
                                cfg.select_active_level);
  assign clk_edge  = sel_on_f & (filt[`SSP_IN_CLK] ^ clk_d);
  // sampling edge ends at level ~(polarity ^ phase)
  assign at_sample = clk_edge & (filt[`SSP_IN_CLK] ==
         ~(cfg.clock_idle_polarity ^ cfg.sample_edge_phase));
  assign at_shift  = clk_edge & ~at_sample;
  // a toggle during deselect comes from the link reset, not a byte
  assign byte_evt  = sel_on_f & sel_d &
                     (filt[`SSP_IN_TGL] ^ tgl_d);
  assign rx_byte   = lbyte;
  assign is_reset  = (rx_byte == `SSP_RESET_BYTE);
  assign ctrl_cnt  = rx_byte[`SSP_CNT_HI:`SSP_CNT_LO];
  assign ctrl_bad  = (|rx_byte[`SSP_SYNC_HI:`SSP_SYNC_LO]) |
                     (ctrl_cnt == `SSP_CNT_ZERO);
  assign last      = (cnt == `SSP_CNT_ONE);
  assign do_load   = pend & nxt_ok;
  // first read fetched as soon as a read control byte is accepted
  assign rd_first  = byte_evt & (st == SSP_CTRL) & ~is_reset &
                     ~ctrl_bad & ~rx_byte[`SSP_DIR_BIT];
  // prefetch the next read byte each time one is put on the line
  assign rd_more   = do_load & (st == SSP_DATA) & ~dir &
                     (rd_left != `SSP_CNT_ZERO);
  assign issue_rd  = rd_first | rd_more;
  assign do_write  = byte_evt & (st == SSP_DATA) & dir;
  assign fill_evt  = byte_evt & ~nxt_ok & ~rd_first &
                     (st != SSP_ADDR) & (st != SSP_IDLE);
  assign sync_a    = cfg.sync_echo_enable ? `SSP_SYNC_FIRST
                                          : `SSP_FILL_BYTE;
  assign sync_b    = cfg.sync_echo_enable ? `SSP_SYNC_SECOND
                                          : `SSP_FILL_BYTE;

  // protocol next state
  always_comb begin
    next_st = st;
    case (st)
      SSP_IDLE: begin
        next_st = SSP_ADDR;
      end
      SSP_ADDR: begin
        if (byte_evt & ~is_reset) begin
          next_st = SSP_CTRL;
        end
      end
      SSP_CTRL: begin
        if (byte_evt) begin
          if (is_reset) begin
            next_st = SSP_ADDR;
          end else if (ctrl_bad) begin
            next_st = SSP_HUNT;
          end else begin
            next_st = SSP_DATA;
          end
        end
      end
      SSP_DATA: begin
        if (byte_evt & last) begin
          next_st = SSP_DONE;
        end
      end
      SSP_HUNT: begin
        if (byte_evt & is_reset) begin
          next_st = SSP_ADDR;
        end
      end
      SSP_DONE: begin
        next_st = SSP_DONE;
      end
      default: begin
        next_st = SSP_IDLE;
      end
    endcase
  end

  // protocol registers and memory requests
  always_ff @(posedge sys_clk_i) begin
    if (rst_i | ~sel_on_f) begin
      st      <= SSP_IDLE;
      addr    <= 8'h00;
      cnt     <= 4'h0;
      dir     <= 1'b0;
      rd_left <= 4'h0;
      rd_wait <= 1'b0;
      mem_req <= '0;
    end else begin
      st          <= next_st;
      rd_wait     <= issue_rd;
      mem_req.rd  <= issue_rd;
      mem_req.wr  <= do_write;
      mem_req.addr  <= addr;
      mem_req.wdata <= rx_byte;
      if (issue_rd | do_write) begin
        addr <= addr + 8'h01;
      end else if (byte_evt & (st == SSP_ADDR) & ~is_reset) begin
        addr <= rx_byte;
      end
      if (byte_evt & (st == SSP_CTRL)) begin
        dir     <= rx_byte[`SSP_DIR_BIT];
        cnt     <= ctrl_cnt;
        rd_left <= ctrl_cnt - `SSP_CNT_ONE;
      end else if (byte_evt & (st == SSP_DATA)) begin
        cnt <= cnt - `SSP_CNT_ONE;
      end
      if (rd_more) begin
        rd_left <= rd_left - `SSP_CNT_ONE;
      end
    end
  end

  // transmit side: byte loads, shifting and sync echo
  always_ff @(posedge sys_clk_i) begin
    if (rst_i | ~sel_on_f) begin
      tx_sh   <= 8'h00;
      next_tx <= sync_a;
      nxt_ok  <= 1'b1;
      // sample-first phase needs the msb before the first edge
      pend    <= ~cfg.sample_edge_phase;
      lc      <= 2'h0;
      scnt    <= 3'h0;
    end else begin
      if (at_sample) begin
        scnt <= scnt + 3'h1;
      end
      if (do_load) begin
        tx_sh <= next_tx;
        pend  <= 1'b0;
      end else if (at_shift & (scnt != 3'h0)) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
      if (at_shift & (scnt == 3'h0)) begin
        pend <= 1'b1;
      end
      if (do_load & (lc != `SSP_LOAD_SAT)) begin
        lc <= lc + 2'h1;
      end
      // the read data path never looks at the input line
      if (rd_wait) begin
        next_tx <= mem_rdata_i;
        nxt_ok  <= 1'b1;
      end else if (do_load) begin
        if (lc == 2'h0) begin
          next_tx <= sync_b;
          nxt_ok  <= 1'b1;
        end else if ((lc == 2'h1) | rd_more) begin
          nxt_ok  <= 1'b0;
        end else begin
          next_tx <= `SSP_FILL_BYTE;
          nxt_ok  <= 1'b1;
        end
      end else if (fill_evt) begin
        next_tx <= `SSP_FILL_BYTE;
        nxt_ok  <= 1'b1;
      end
    end
  end

  // output line released at once when the raw select drops
  assign miso_o    = tx_sh[7];
  assign miso_oe_o = sel_on_f &
                     ssp_sel_on(select_i, cfg.select_active_level);

  assign mem_req_o = mem_req;
  assign cfg_o     = cfg;
  assign stat_o.selected          = sel_on_f;
  assign stat_o.resync_needed     = (st == SSP_HUNT);
  assign stat_o.busy              = (st == SSP_DATA);
  assign stat_o.serial_byte_count = cnt;

endmodule

`default_nettype wire
